// file: verilog/ctp_top.v
// timer pair block top: axi4-lite slave, register file and pair joining
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "ctp_defines.vh"
// ====================================================================

module ctp_top (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // axi4-lite write address
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_awaddr_i,
  // axi4-lite write data
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  // axi4-lite write response
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  output reg [1:0] s_axi_bresp_o,
  // axi4-lite read address
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  input wire [31:0] s_axi_araddr_i,
  // axi4-lite read data
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  // timer pins, index 0 is pair a
  input wire [1:0] lower_ext_clock_pin_i,
  input wire [1:0] upper_ext_clock_pin_i,
  input wire idle_i,
  // events toward the rest of the chip
  output reg [3:0] timer_flag_o,
  output reg [3:0] dma_req_o,
  output reg adc_trig_o,
  output reg [3:0] timebase_tick_o
);

  // ==================================================================
  // helpers
  // byte-lane merge of the low 16 bits; upper lanes hold nothing
  function [15:0] ctp_merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      ctp_merge = {(strb[1] ? data[15:8] : old[15:8]), (strb[0] ? data[7:0] : old[7:0])};
    end
  endfunction

  // mapped: two pairs of eight aligned words, nothing else
  function ctp_addr_ok;
    input [31:0] a;
    begin
      ctp_addr_ok = (a[31:7] == 25'h0) && (a[5] == 1'b0) && (a[1:0] == 2'b00);
    end
  endfunction

  // ==================================================================
  // register storage, pair a in the low slice

  reg [31:0] ctl_lo;
  reg [31:0] ctl_hi;
  reg [31:0] per_lo;
  reg [31:0] per_hi;
  reg [31:0] hold;
  wire [31:0] cnt_lo;
  wire [31:0] cnt_hi;

  // write channel holding state
  reg aw_held;
  reg w_held;
  reg [31:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // per-timer event vectors, bit 2p is lower, 2p+1 upper of pair p
  wire [3:0] flag_set;
  wire [3:0] match_ev;
  wire [3:0] tick_v;

  // ==================================================================
  // write decode

  wire wr_fire;
  wire wr_ok;
  wire wp;
  wire [2:0] wreg;
  wire [15:0] wsel_cnt;
  wire [15:0] ld_val;
  wire [1:0] ld_lo;
  wire [1:0] ld_hi;
  wire [1:0] clr_bits;
  wire [3:0] flag_clr;

  // a write goes ahead once address and data are both in and the last answer is gone
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid_o;
  assign wr_ok = ctp_addr_ok(aw_addr);
  assign wp = aw_addr[`CTP_PAIR_SEL_BIT];
  assign wreg = aw_addr[4:2];

  // count loads merge lanes with the live count
  assign wsel_cnt = (wreg == `CTP_IDX_LO_CNT) ? cnt_lo[wp * 16 +: 16] : cnt_hi[wp * 16 +: 16];
  assign ld_val = ctp_merge(wsel_cnt, w_data, w_strb);
  assign ld_lo[0] = wr_fire & wr_ok & ~wp & (wreg == `CTP_IDX_LO_CNT);
  assign ld_lo[1] = wr_fire & wr_ok & wp & (wreg == `CTP_IDX_LO_CNT);
  assign ld_hi[0] = wr_fire & wr_ok & ~wp & (wreg == `CTP_IDX_HI_CNT);
  assign ld_hi[1] = wr_fire & wr_ok & wp & (wreg == `CTP_IDX_HI_CNT);

  // flags clear by writing ones
  assign clr_bits = (wr_fire & wr_ok & (wreg == `CTP_IDX_FLAGS) & w_strb[0]) ?
                    (w_data[1:0] & `CTP_FLAG_MASK) : 2'b00;
  assign flag_clr = wp ? {clr_bits, 2'b00} : {2'b00, clr_bits};

  // ==================================================================
  // the two pairs

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : pair
      wire [15:0] cl;
      wire [15:0] ch;
      wire joined;
      wire tick_lo;
      wire tick_hi_raw;
      wire gf_lo;
      wire gf_hi;
      wire m16_lo;
      wire m16_hi;
      wire m32;
      wire lo_clear;
      wire hi_clear;
      wire hi_tick;

      assign cl = ctl_lo[g * 16 +: 16];
      assign ch = ctl_hi[g * 16 +: 16];
      assign joined = cl[`CTP_BIT_JOIN];

      // the lower source also drives the joined pair, so both idle bits stop it
      ctp_tick u_tick_lo (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .run_i(cl[`CTP_BIT_RUN]),
        .halt_i(idle_i & (cl[`CTP_BIT_IDLE] | (joined & ch[`CTP_BIT_IDLE]))),
        .ext_sel_i(cl[`CTP_BIT_CS]),
        .gate_en_i(cl[`CTP_BIT_GATE]),
        .prescale_i(cl[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO]),
        .pin_i(lower_ext_clock_pin_i[g]),
        .tick_o(tick_lo),
        .gate_fall_o(gf_lo)
      );

      // upper source is held stopped while joined
      ctp_tick u_tick_hi (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .run_i(ch[`CTP_BIT_RUN] & ~joined),
        .halt_i(idle_i & ch[`CTP_BIT_IDLE]),
        .ext_sel_i(ch[`CTP_BIT_CS]),
        .gate_en_i(ch[`CTP_BIT_GATE]),
        .prescale_i(ch[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO]),
        .pin_i(upper_ext_clock_pin_i[g]),
        .tick_o(tick_hi_raw),
        .gate_fall_o(gf_hi)
      );

      // period compares, 16-bit each and 32-bit joined
      assign m16_lo = (cnt_lo[g * 16 +: 16] == per_lo[g * 16 +: 16]);
      assign m16_hi = (cnt_hi[g * 16 +: 16] == per_hi[g * 16 +: 16]);
      assign m32 = m16_lo & m16_hi;

      // joined: upper word advances on lower carry, lower is the least significant word
      assign lo_clear = joined ? m32 : m16_lo;
      assign hi_clear = joined ? m32 : m16_hi;
      assign hi_tick = joined ?
                       (tick_lo & ((cnt_lo[g * 16 +: 16] == `CTP_WORD_MAX) | m32)) :
                       tick_hi_raw;

      ctp_count16 u_cnt_lo (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tick_i(tick_lo),
        .clear_i(lo_clear),
        .load_i(ld_lo[g]),
        .load_val_i(ld_val),
        .count_o(cnt_lo[g * 16 +: 16])
      );

      ctp_count16 u_cnt_hi (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tick_i(hi_tick),
        .clear_i(hi_clear),
        .load_i(ld_hi[g]),
        .load_val_i(ld_val),
        .count_o(cnt_hi[g * 16 +: 16])
      );

      // joined events all land on the upper flag
      assign match_ev[2 * g] = ~joined & tick_lo & m16_lo;
      assign match_ev[2 * g + 1] = joined ? (tick_lo & m32) : (tick_hi_raw & m16_hi);
      assign flag_set[2 * g] = match_ev[2 * g] | (~joined & gf_lo);
      assign flag_set[2 * g + 1] = match_ev[2 * g + 1] | (joined ? gf_lo : gf_hi);
      assign tick_v[2 * g] = tick_lo;
      assign tick_v[2 * g + 1] = hi_tick;
    end
  endgenerate

  // ==================================================================
  // read decode

  wire rp;
  wire [2:0] rreg;
  wire rd_ok;
  reg [15:0] rd_word;

  assign rp = s_axi_araddr_i[`CTP_PAIR_SEL_BIT];
  assign rreg = s_axi_araddr_i[4:2];
  assign rd_ok = ctp_addr_ok(s_axi_araddr_i);

  // unimplemented control bits come back as zero
  always @* begin
    case (rreg)
      `CTP_IDX_LO_CTL: rd_word = ctl_lo[rp * 16 +: 16] & `CTP_LO_CTL_MASK;
      `CTP_IDX_HI_CTL: rd_word = ctl_hi[rp * 16 +: 16] & `CTP_HI_CTL_MASK;
      `CTP_IDX_LO_CNT: rd_word = cnt_lo[rp * 16 +: 16];
      `CTP_IDX_HI_CNT: rd_word = cnt_hi[rp * 16 +: 16];
      `CTP_IDX_LO_PER: rd_word = per_lo[rp * 16 +: 16];
      `CTP_IDX_HI_PER: rd_word = per_hi[rp * 16 +: 16];
      `CTP_IDX_HOLD: rd_word = hold[rp * 16 +: 16];
      default: rd_word = {14'h0000, timer_flag_o[rp * 2 +: 2]};
    endcase
  end

  // ==================================================================
  // write channels, registers and response

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `CTP_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctl_lo <= {`CTP_CTL_RESET, `CTP_CTL_RESET};
      ctl_hi <= {`CTP_CTL_RESET, `CTP_CTL_RESET};
      per_lo <= {`CTP_PER_RESET, `CTP_PER_RESET};
      per_hi <= {`CTP_PER_RESET, `CTP_PER_RESET};
    end else begin
      // address and data are taken in either order
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? `CTP_RESP_OKAY : `CTP_RESP_SLVERR;
        if (wr_ok) begin
          case (wreg)
            `CTP_IDX_LO_CTL: ctl_lo[wp * 16 +: 16] <=
              ctp_merge(ctl_lo[wp * 16 +: 16], w_data, w_strb) & `CTP_LO_CTL_MASK;
            `CTP_IDX_HI_CTL: ctl_hi[wp * 16 +: 16] <=
              ctp_merge(ctl_hi[wp * 16 +: 16], w_data, w_strb) & `CTP_HI_CTL_MASK;
            `CTP_IDX_LO_PER: per_lo[wp * 16 +: 16] <=
              ctp_merge(per_lo[wp * 16 +: 16], w_data, w_strb);
            `CTP_IDX_HI_PER: per_hi[wp * 16 +: 16] <=
              ctp_merge(per_hi[wp * 16 +: 16], w_data, w_strb);
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ==================================================================
  // read channel and coherent hold word

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `CTP_RESP_OKAY;
      hold <= 32'h0000_0000;
    end else begin
      if (wr_fire && wr_ok && (wreg == `CTP_IDX_HOLD)) begin // a same-edge snapshot wins
        hold[wp * 16 +: 16] <= ctp_merge(hold[wp * 16 +: 16], w_data, w_strb);
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_ok ? {16'h0000, rd_word} : 32'h0000_0000;
        s_axi_rresp_o <= rd_ok ? `CTP_RESP_OKAY : `CTP_RESP_SLVERR;
        // snapshot the upper word with the lower read so a carry between reads is harmless
        if (rd_ok && (rreg == `CTP_IDX_LO_CNT) && ctl_lo[rp * 16 + `CTP_BIT_JOIN]) begin
          hold[rp * 16 +: 16] <= cnt_hi[rp * 16 +: 16];
        end
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ==================================================================
  // flags and event outputs

  // a flag event in the cycle of its clear survives
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      timer_flag_o <= 4'h0;
      dma_req_o <= 4'h0;
      adc_trig_o <= 1'b0;
      timebase_tick_o <= 4'h0;
    end else begin
      timer_flag_o <= (timer_flag_o & ~flag_clr) | flag_set;
      dma_req_o <= match_ev;
      adc_trig_o <= match_ev[1];
      timebase_tick_o <= tick_v;
    end
  end

endmodule

// file: verilog/ctp_defines.vh
// register map, field positions, reset values and bus codes of the timer pair block
`ifndef CTP_DEFINES_VH
`define CTP_DEFINES_VH

// ====================================================================
// register offsets inside one pair (byte addresses, bits 4:2)
`define CTP_IDX_LO_CTL 3'h0
`define CTP_IDX_HI_CTL 3'h1
`define CTP_IDX_LO_CNT 3'h2
`define CTP_IDX_HI_CNT 3'h3
`define CTP_IDX_LO_PER 3'h4
`define CTP_IDX_HI_PER 3'h5
`define CTP_IDX_HOLD 3'h6
`define CTP_IDX_FLAGS 3'h7
// address bit that selects pair b, base of pair b is 0x40
`define CTP_PAIR_SEL_BIT 6
`define CTP_PAIR_B_BASE 32'h0000_0040

// ====================================================================
// control register fields
`define CTP_BIT_RUN 15
`define CTP_BIT_IDLE 13
`define CTP_BIT_GATE 6
`define CTP_BIT_PS_HI 5
`define CTP_BIT_PS_LO 4
`define CTP_BIT_JOIN 3
`define CTP_BIT_CS 1
// implemented bits; everything else reads zero
`define CTP_LO_CTL_MASK 16'hA07A
`define CTP_HI_CTL_MASK 16'hA072
`define CTP_FLAG_MASK 2'h3

// ====================================================================
// reset values
`define CTP_CTL_RESET 16'h0000
`define CTP_CNT_RESET 16'h0000
`define CTP_PER_RESET 16'hFFFF
`define CTP_WORD_MAX 16'hFFFF

// ====================================================================
// prescaler terminal counts (divide by n means count 0 .. n-1)
`define CTP_PS_DIV1 8'h00
`define CTP_PS_DIV8 8'h07
`define CTP_PS_DIV64 8'h3F
`define CTP_PS_DIV256 8'hFF

// ====================================================================
// axi response codes
`define CTP_RESP_OKAY 2'h0
`define CTP_RESP_SLVERR 2'h2

`endif

// file: verilog/ctp_tick.v
// count-enable generator: clock source select, gating, prescaler and idle halt
`timescale 1ns/100ps
`include "ctp_defines.vh"

module ctp_tick (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // configuration
  input wire run_i,
  input wire halt_i,
  input wire ext_sel_i,
  input wire gate_en_i,
  input wire [1:0] prescale_i,
  // external clock / gate pin
  input wire pin_i,
  // events
  output wire tick_o,
  output wire gate_fall_o
);

  reg pin_q;
  reg [7:0] ps_cnt;
  reg [7:0] ps_limit;
  wire gated;
  wire src;
  wire active;

  // divider terminal count per prescale code
  always @* begin
    case (prescale_i)
      2'b00: ps_limit = `CTP_PS_DIV1;
      2'b01: ps_limit = `CTP_PS_DIV8;
      2'b10: ps_limit = `CTP_PS_DIV64;
      default: ps_limit = `CTP_PS_DIV256;
    endcase
  end

  // pin edges are seen on the system clock only, so no asynchronous counting exists
  assign gated = ~ext_sel_i & gate_en_i;
  assign src = ext_sel_i ? (pin_i & ~pin_q) : (gated ? pin_i : 1'b1);
  assign active = run_i & ~halt_i;
  assign tick_o = active & src & (ps_cnt == ps_limit);
  assign gate_fall_o = active & gated & pin_q & ~pin_i;

  // prescaler restarts whenever run is cleared; an idle halt only holds it
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
      ps_cnt <= 8'h00;
    end else begin
      pin_q <= pin_i;
      if (!run_i) begin
        ps_cnt <= 8'h00;
      end else if (active && src) begin
        ps_cnt <= (ps_cnt == ps_limit) ? 8'h00 : ps_cnt + 8'h01;
      end
    end
  end

endmodule

// file: verilog/ctp_count16.v
// one 16-bit count word with software load and period clear
`timescale 1ns/100ps
`include "ctp_defines.vh"

module ctp_count16 (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // counting
  input wire tick_i,
  input wire clear_i,
  // software load
  input wire load_i,
  input wire [15:0] load_val_i,
  // state
  output reg [15:0] count_o
);

  // a software write wins over a tick in the same cycle; that tick is lost
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_o <= `CTP_CNT_RESET;
    end else if (load_i) begin
      count_o <= load_val_i;
    end else if (tick_i) begin
      count_o <= clear_i ? `CTP_CNT_RESET : count_o + 16'h0001;
    end
  end

endmodule

// file: dv/ctp_top_properties.sv
// concurrent checks on the ports of the timer pair block
`timescale 1ns/100ps

module ctp_top_chk (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // register bus
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_araddr_i,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0] s_axi_rresp_o,
  // events
  input wire [3:0] timer_flag_o,
  input wire [3:0] dma_req_o,
  input wire adc_trig_o
);
  // ====================================================================
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // reset itself is the cause here, so this one is never disabled
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    rst_i |=> timer_flag_o == 4'h0 && dma_req_o == 4'h0 && !adc_trig_o)
    else $error("events not quiet after reset");
  // a dma pulse and its flag are raised on the same edge
  AST_DMA_FLAG: assert property ((dma_req_o & ~timer_flag_o) == 4'h0)
    else $error("dma pulse without its flag");
  AST_ADC_FLAG: assert property (adc_trig_o |-> timer_flag_o[1])
    else $error("adc trigger without pair a upper flag");
  AST_ADC_NOT_B: assert property (adc_trig_o |-> dma_req_o[1])
    else $error("pair b drove the adc trigger");
  AST_BHOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  AST_RHOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read data dropped early");
  AST_RANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read not answered one cycle after address");
  AST_WANSWER: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o && !s_axi_bvalid_o |-> ##[1:2] s_axi_bvalid_o)
    else $error("write not answered in time");
  // unmapped: high bits, the hole at bit 5 or a misaligned offset
  AST_UNMAPPED: assert property (s_axi_arvalid_i && s_axi_arready_o &&
    (s_axi_araddr_i[31:7] != 25'h0 || s_axi_araddr_i[5] || s_axi_araddr_i[1:0] != 2'h0)
    |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule

bind ctp_top ctp_top_chk u_chk (.sys_clk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i,
  .s_axi_rdata_o, .s_axi_rresp_o, .timer_flag_o, .dma_req_o, .adc_trig_o);

// file: dv/ctp_pin_model.sv
// model of the external clock and gate pins of both pairs
`timescale 1ns/100ps

module ctp_pin_model (
  // clock
  input wire logic sys_clk_i,
  // pins {b_up, b_lo, a_up, a_lo}
  output logic [3:0] pins_o
);
  // pins rest low between bursts, like a stopped clock source
  initial pins_o = 4'h0;

  // ====================================================================
  // n rising edges, each level held len cycles so the synchroniser sees it
  task automatic edges(input int sel, input int n, input int len);
    repeat (n) begin
      @(posedge sys_clk_i);
      pins_o[sel] <= 1'b1;
      repeat (len) @(posedge sys_clk_i);
      pins_o[sel] <= 1'b0;
      repeat (len - 1) @(posedge sys_clk_i);
    end
  endtask

  // gate held high for n cycles, then a falling edge
  task automatic hold_high(input int sel, input int n);
    @(posedge sys_clk_i);
    pins_o[sel] <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    pins_o[sel] <= 1'b0;
  endtask
endmodule

// file: dv/tb_top.sv
// self-checking testbench of the timer pair block
`timescale 1ns/100ps

module tb_top;
  // ====================================================================
  // stimulus and observation
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
  logic idle = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, adc;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] pins, flags, dma, tick;
  int fails = 0;
  int n_tests = 0;
  int k;
  logic [31:0] rd, rd2, hold, base, ex;
  logic [1:0] resp;
  logic [3:0] dma_seen = 4'h0;
  logic [3:0] tick_seen = 4'h0;
  logic adc_seen = 1'b0;
  localparam logic [31:0] LCTL = 32'h0000_0000, HCTL = 32'h0000_0004, LCNT = 32'h0000_0008,
    HCNT = 32'h0000_000C, LPER = 32'h0000_0010, HPER = 32'h0000_0014,
    HOLDR = 32'h0000_0018, FLG = 32'h0000_001C, PB = 32'h0000_0040;

  always #5 sys_clk_i = ~sys_clk_i;

  ctp_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .lower_ext_clock_pin_i({pins[2], pins[0]}), .upper_ext_clock_pin_i({pins[3], pins[1]}),
    .idle_i(idle), .timer_flag_o(flags), .dma_req_o(dma), .adc_trig_o(adc),
    .timebase_tick_o(tick));

  ctp_pin_model pins_m (.sys_clk_i(sys_clk_i), .pins_o(pins));

  // pulses are one cycle wide, so collect them as they pass
  // outputs are unknown before the first reset edge, so collect only after reset
  always @(posedge sys_clk_i) begin
    if (!rst_i) begin
      dma_seen <= dma_seen | dma;
      tick_seen <= tick_seen | tick;
      adc_seen <= adc_seen | (adc === 1'b1);
    end
  end

  // ====================================================================
  // comparison and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ====================================================================
  // bus cycles: address and data offered together, each dropped when taken
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk_i);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0000, d};
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk_i);
      if (awvalid && awready === 1'b1) aw_ok = 1'b1;
      if (wvalid && wready === 1'b1) w_ok = 1'b1;
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(posedge sys_clk_i); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge sys_clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk_i); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // watchdog well beyond the roughly 9000 cycles the tests need
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    fails++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // reset values, dropped bits and refused addresses
    rd_reg(LCTL, rd);
    chk(rd, 32'h0000_0000);
    rd_reg(PB + LPER, rd);
    chk(rd, 32'h0000_FFFF);
    wr(LCTL, 16'h5F85);
    rd_reg(LCTL, rd);
    chk(rd, 32'h0000_0000);
    wr(HCTL, 16'h7FFF);
    rd_reg(HCTL, rd);
    chk(rd, 32'h0000_2072);
    wr(HCTL, 16'h0000);
    rd_reg(32'h0000_0020, rd);
    chk(resp, 2'h2);
    chk(rd, 32'h0000_0000);
    wr(32'h0000_0082, 16'h8000);
    chk(resp, 2'h2);
    // each of the four split timers: period match clears count and sets the flag
    for (int i = 0; i < 4; i++) begin
      base = (i / 2) * PB + (i % 2) * 4;
      wr(base + LPER, 16'h0005);
      wr(base, 16'h8000);
      k = 0;
      while (flags[i] !== 1'b1 && k < 50) begin
        @(posedge sys_clk_i);
        k++;
      end
      chk(flags[i], 1'b1);
      wr(base, 16'h0000);
      rd_reg(base + LCNT, rd);
      chk(rd <= 5, 1'b1);
      wr((i / 2) * PB + FLG, 16'h0001 << (i % 2));
      rd_reg((i / 2) * PB + FLG, rd);
      chk(rd, 32'h0000_0000);
    end
    chk(dma_seen, 4'hF);
    chk(adc_seen, 1'b1);
    chk(tick_seen, 4'hF);
    // prescale codes, then a stopped count must stand still
    wr(LPER, 16'hFFFF);
    for (int c = 0; c < 4; c++) begin
      ex = 2048 >> (c == 3 ? 8 : 3 * c);
      wr(LCNT, 16'h0000);
      wr(LCTL, 16'h8000 | (c << 4));
      repeat (2048) @(posedge sys_clk_i);
      wr(LCTL, 16'h0000);
      rd_reg(LCNT, rd);
      chk(rd + 1 >= ex && rd <= ex + 8, 1'b1);
      repeat (20) @(posedge sys_clk_i);
      rd_reg(LCNT, rd2);
      chk(rd2, rd);
    end
    // joined pair in idle: upper control ignored except its idle bit
    wr(LCNT, 16'h0000);
    wr(HCTL, 16'h2030);
    wr(LCTL, 16'h8008);
    idle <= 1'b1;
    rd_reg(LCNT, rd);
    repeat (40) @(posedge sys_clk_i);
    rd_reg(LCNT, rd2);
    chk(rd2, rd);
    wr(HCTL, 16'h0030);
    rd_reg(LCNT, rd);
    repeat (40) @(posedge sys_clk_i);
    rd_reg(LCNT, rd2);
    chk(rd2 - rd > 40, 1'b1);
    idle <= 1'b0;
    // carry into the upper word and the coherent hold copy
    wr(LCTL, 16'h0008);
    wr(LCNT, 16'hFFF0);
    wr(HCNT, 16'h0002);
    wr(LCTL, 16'h8008);
    repeat (30) @(posedge sys_clk_i);
    wr(LCTL, 16'h0008);
    rd_reg(LCNT, rd);
    rd_reg(HOLDR, hold);
    rd_reg(HCNT, rd2);
    chk(hold, rd2);
    chk({hold[15:0], rd[15:0]} > 32'h0003_0000, 1'b1);
    // 32-bit period match reported on the upper flag only
    wr(FLG, 16'h0003);
    wr(LCNT, 16'hFFFE);
    wr(HCNT, 16'h0000);
    wr(HPER, 16'h0001);
    wr(LPER, 16'h0002);
    wr(LCTL, 16'h8008);
    k = 0;
    while (flags[1] !== 1'b1 && k < 50) begin
      @(posedge sys_clk_i);
      k++;
    end
    chk(flags[1:0], 2'b10);
    wr(LCTL, 16'h0000);
    rd_reg(HCNT, rd);
    chk(rd, 32'h0000_0000);
    // pair b lower gated by its pin, then counting pin edges with gate ignored
    wr(PB + LPER, 16'hFFFF);
    wr(PB + LCNT, 16'h0000);
    wr(PB + LCTL, 16'h8040);
    pins_m.hold_high(2, 50);
    repeat (5) @(posedge sys_clk_i);
    wr(PB + LCTL, 16'h0000);
    rd_reg(PB + LCNT, rd);
    chk(rd >= 47 && rd <= 53, 1'b1);
    chk(flags[2], 1'b1);
    wr(PB + LCNT, 16'h0000);
    wr(PB + LCTL, 16'h8042);
    pins_m.edges(2, 12, 2);
    pins_m.edges(2, 8, 5);
    repeat (10) @(posedge sys_clk_i);
    wr(PB + LCTL, 16'h0000);
    rd_reg(PB + LCNT, rd);
    chk(rd, 32'h0000_0014);
    tally_and_finish();
  end
endmodule
